// ===== ppc_clock_control.sv
// pwm prescale and loop clock control: run-mode clock configuration bits 20:10 plus interrupt registers
// assumes an axi4-lite master on i_clk; loop heartbeat arrives asynchronously from the loop clock
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
module ppc_clock_control
    import ppc_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // axi4-lite write address
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [ppc_pkg::ADDR_W-1:0] i_awaddr,
    // axi4-lite write data
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // axi4-lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // axi4-lite read address
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [ppc_pkg::ADDR_W-1:0] i_araddr,
    // axi4-lite read data
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // neighbouring clock logic
    input wire logic i_system_divider_enable,
    input wire logic i_loop_beat,
    // clock controls
    output logic o_pwm_clk_en,
    output logic o_loop_power_down,
    output logic o_loop_output_enable,
    output logic o_source_select,
    output logic o_use_system_divider,
    output ppc_pkg::ppc_clk_cfg_t o_clk_cfg,
    // interrupt
    output logic o_irq
);
    import ppc_pkg::*;

    typedef struct packed {
        ppc_clk_cfg_t cfg;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic aw_got;
        logic [ADDR_W-1:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic use_div;
        logic irq;
    } ppc_top_state_t;

    localparam ppc_top_state_t TOP_RESET = '{
        cfg: CLK_CFG_RESET,
        irq_status: '0,
        irq_mask: IRQ_MASK_RESET,
        aw_got: 1'b0,
        awaddr: '0,
        w_got: 1'b0,
        wdata: '0,
        wstrb: '0,
        awready: 1'b1,
        wready: 1'b1,
        bvalid: 1'b0,
        bresp: RESP_OKAY,
        arready: 1'b1,
        rvalid: 1'b0,
        rresp: RESP_OKAY,
        rdata: '0,
        use_div: 1'b0,
        irq: 1'b0
    };

    ppc_top_state_t state_ff;
    ppc_top_state_t nxt_state;
    logic loop_fail;
    logic loop_back;
    logic verify_run;

    // reserved bits are simply never packed, so they read as zero
    function automatic logic [31:0] pack_cfg(input ppc_clk_cfg_t c);
        logic [31:0] w;
        w = '0;
        w[PWM_PRESCALE_ENABLE_BIT] = c.pwm_prescale_enable;
        w[PWM_PRESCALE_SELECT_LSB +: 3] = c.pwm_prescale_select;
        w[LOOP_POWER_DOWN_BIT] = c.loop_power_down;
        w[LOOP_OUTPUT_ENABLE_BIT] = c.loop_output_enable;
        w[SOURCE_SELECT_BIT] = c.source_select;
        w[LOOP_VERIFY_ENABLE_BIT] = c.loop_verify_enable;
        return w;
    endfunction

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wr,
                                                input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = wr[i*8 +: 8];
            end
        end
        return m;
    endfunction

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        return (a[ADDR_W-1:2] == RUN_MODE_CLOCK_CONFIGURATION_OFFSET[ADDR_W-1:2])
            || (a[ADDR_W-1:2] == IRQ_STATUS_OFFSET[ADDR_W-1:2])
            || (a[ADDR_W-1:2] == IRQ_MASK_OFFSET[ADDR_W-1:2]);
    endfunction

    // the timer is only meaningful once the loop is powered and driving its output
    assign verify_run = state_ff.cfg.loop_verify_enable && !state_ff.cfg.loop_power_down
        && !state_ff.cfg.loop_output_enable;

    always_comb begin
        logic [31:0] cfg_word;
        logic [IRQ_W-1:0] clr;
        logic [IRQ_W-1:0] ev;
        cfg_word = '0;
        clr = '0;
        ev = '0;
        nxt_state = state_ff;

        // address and data may come in either order
        if (i_awvalid && state_ff.awready) begin
            nxt_state.aw_got = 1'b1;
            nxt_state.awaddr = i_awaddr;
        end
        if (i_wvalid && state_ff.wready) begin
            nxt_state.w_got = 1'b1;
            nxt_state.wdata = i_wdata;
            nxt_state.wstrb = i_wstrb;
        end
        if (state_ff.bvalid && i_bready) begin
            nxt_state.bvalid = 1'b0;
        end

        if (state_ff.aw_got && state_ff.w_got && !state_ff.bvalid) begin
            nxt_state.aw_got = 1'b0;
            nxt_state.w_got = 1'b0;
            nxt_state.bvalid = 1'b1;
            nxt_state.bresp = addr_hit(state_ff.awaddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (state_ff.awaddr[ADDR_W-1:2])
                RUN_MODE_CLOCK_CONFIGURATION_OFFSET[ADDR_W-1:2]: begin
                    cfg_word = merge_bytes(pack_cfg(state_ff.cfg), state_ff.wdata, state_ff.wstrb);
                    nxt_state.cfg.pwm_prescale_enable = cfg_word[PWM_PRESCALE_ENABLE_BIT];
                    nxt_state.cfg.pwm_prescale_select = cfg_word[PWM_PRESCALE_SELECT_LSB +: 3];
                    nxt_state.cfg.loop_power_down = cfg_word[LOOP_POWER_DOWN_BIT];
                    nxt_state.cfg.loop_output_enable = cfg_word[LOOP_OUTPUT_ENABLE_BIT];
                    nxt_state.cfg.source_select = cfg_word[SOURCE_SELECT_BIT];
                    nxt_state.cfg.loop_verify_enable = cfg_word[LOOP_VERIFY_ENABLE_BIT];
                end
                IRQ_STATUS_OFFSET[ADDR_W-1:2]: begin
                    if (state_ff.wstrb[0]) begin
                        clr = state_ff.wdata[IRQ_W-1:0];
                    end
                end
                IRQ_MASK_OFFSET[ADDR_W-1:2]: begin
                    if (state_ff.wstrb[0]) begin
                        nxt_state.irq_mask = state_ff.wdata[IRQ_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // one write in flight: hold both channels until the response is taken
        nxt_state.awready = !nxt_state.aw_got && !nxt_state.bvalid;
        nxt_state.wready = !nxt_state.w_got && !nxt_state.bvalid;

        if (i_arvalid && state_ff.arready) begin
            nxt_state.arready = 1'b0;
            nxt_state.rvalid = 1'b1;
            nxt_state.rresp = addr_hit(i_araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (i_araddr[ADDR_W-1:2])
                RUN_MODE_CLOCK_CONFIGURATION_OFFSET[ADDR_W-1:2]: nxt_state.rdata = pack_cfg(state_ff.cfg);
                IRQ_STATUS_OFFSET[ADDR_W-1:2]: nxt_state.rdata = {30'h0, state_ff.irq_status};
                IRQ_MASK_OFFSET[ADDR_W-1:2]: nxt_state.rdata = {30'h0, state_ff.irq_mask};
                default: nxt_state.rdata = '0;
            endcase
        end else if (state_ff.rvalid && i_rready) begin
            nxt_state.rvalid = 1'b0;
            nxt_state.arready = 1'b1;
        end

        // a new event beats a clear written in the same cycle
        ev[IRQ_LOOP_FAIL_BIT] = loop_fail;
        ev[IRQ_LOOP_BACK_BIT] = loop_back;
        nxt_state.irq_status = (state_ff.irq_status & ~clr) | ev;
        nxt_state.irq = |(nxt_state.irq_status & nxt_state.irq_mask);

        // loop as source always goes through the system divider
        nxt_state.use_div = !nxt_state.cfg.source_select || i_system_divider_enable;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_ff <= TOP_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ppc_prescaler u_prescaler (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_enable(state_ff.cfg.pwm_prescale_enable),
        .i_select(state_ff.cfg.pwm_prescale_select),
        .o_tick(o_pwm_clk_en)
    );

    ppc_loop_monitor u_monitor (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_enable(verify_run),
        .i_loop_beat(i_loop_beat),
        .o_fail(loop_fail),
        .o_back(loop_back)
    );

    assign o_awready = state_ff.awready;
    assign o_wready = state_ff.wready;
    assign o_bvalid = state_ff.bvalid;
    assign o_bresp = state_ff.bresp;
    assign o_arready = state_ff.arready;
    assign o_rvalid = state_ff.rvalid;
    assign o_rdata = state_ff.rdata;
    assign o_rresp = state_ff.rresp;
    assign o_loop_power_down = state_ff.cfg.loop_power_down;
    assign o_loop_output_enable = state_ff.cfg.loop_output_enable;
    assign o_source_select = state_ff.cfg.source_select;
    assign o_use_system_divider = state_ff.use_div;
    assign o_clk_cfg = state_ff.cfg;
    assign o_irq = state_ff.irq;
endmodule

// ===== ppc_pkg.sv
// constants, field layouts and carrier types for the pwm prescale and loop clock control block
// assumes a single 50 MHz system clock and an axi4-lite register bus with 12-bit byte addresses
package ppc_pkg;

    // clock and timing
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned VERIFY_TIMEOUT_NS = 10000;
    localparam int unsigned VERIFY_TIMEOUT_CYC = VERIFY_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int unsigned VERIFY_CNT_W = 10;

    // register map (byte addresses)
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] RUN_MODE_CLOCK_CONFIGURATION_OFFSET = 12'h060;
    localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h050;
    localparam logic [11:0] IRQ_MASK_OFFSET = 12'h054;

    // field positions in run_mode_clock_configuration
    localparam int unsigned PWM_PRESCALE_ENABLE_BIT = 20;
    localparam int unsigned PWM_PRESCALE_SELECT_LSB = 17;
    localparam int unsigned LOOP_POWER_DOWN_BIT = 13;
    localparam int unsigned LOOP_OUTPUT_ENABLE_BIT = 12;
    localparam int unsigned SOURCE_SELECT_BIT = 11;
    localparam int unsigned LOOP_VERIFY_ENABLE_BIT = 10;

    // interrupt status layout
    localparam int unsigned IRQ_W = 2;
    localparam int unsigned IRQ_LOOP_FAIL_BIT = 0;
    localparam int unsigned IRQ_LOOP_BACK_BIT = 1;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // prescaler
    localparam int unsigned PRESCALE_CNT_W = 6;

    typedef struct packed {
        logic pwm_prescale_enable;
        logic [2:0] pwm_prescale_select;
        logic loop_power_down;
        logic loop_output_enable;
        logic source_select;
        logic loop_verify_enable;
    } ppc_clk_cfg_t;

    localparam ppc_clk_cfg_t CLK_CFG_RESET = '{
        pwm_prescale_enable: 1'b0,
        pwm_prescale_select: 3'h7,
        loop_power_down: 1'b1,
        loop_output_enable: 1'b1,
        source_select: 1'b1,
        loop_verify_enable: 1'b0
    };

    // divide mask: the tick fires when the counter's low bits are all ones
    function automatic logic [5:0] ppc_div_mask(input logic [2:0] sel);
        logic [5:0] m;
        m = 6'h3f;
        unique case (sel)
            3'h0: m = 6'h01;
            3'h1: m = 6'h03;
            3'h2: m = 6'h07;
            3'h3: m = 6'h0f;
            3'h4: m = 6'h1f;
            default: m = 6'h3f;
        endcase
        return m;
    endfunction

endpackage

// ===== ppc_prescaler.sv
// pwm clock prescaler: one-cycle enable pulse at sysclk / 2^(n+1) for n up to 5, and sysclk / 64 for n of 5 to 7
// assumes the pwm module clocks on i_clk and qualifies with the enable
`timescale 1ns/10ps
module ppc_prescaler
    import ppc_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // control
    input wire logic i_enable,
    input wire logic [2:0] i_select,
    // pwm timing enable
    output logic o_tick
);
    typedef struct packed {
        logic [5:0] cnt;
        logic tick;
    } ppc_pre_state_t;

    ppc_pre_state_t state_ff;
    ppc_pre_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.cnt = state_ff.cnt + 6'h01;
        // power-of-two division only, ticks land on sysclk edges with no offset
        // with the prescaler off the pwm sees every system clock edge
        nxt_state.tick = !i_enable || ((state_ff.cnt & ppc_div_mask(i_select)) == ppc_div_mask(i_select));
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_tick = state_ff.tick;
endmodule

// ===== ppc_loop_monitor.sv
// loop verification timer: watches a heartbeat toggle from the loop clock domain
// assumes i_loop_beat toggles at least once per timeout while the loop runs
`timescale 1ns/10ps
module ppc_loop_monitor
    import ppc_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // control and heartbeat
    input wire logic i_enable,
    input wire logic i_loop_beat,
    // events
    output logic o_fail,
    output logic o_back
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic [9:0] cnt;
        logic failed;
        logic fail;
        logic back;
    } ppc_mon_state_t;

    ppc_mon_state_t state_ff;
    ppc_mon_state_t nxt_state;
    logic beat;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.s1 = i_loop_beat;
        nxt_state.s2 = state_ff.s1;
        nxt_state.s3 = state_ff.s2;
        nxt_state.fail = 1'b0;
        nxt_state.back = 1'b0;
        beat = (state_ff.s2 == state_ff.s3) && (state_ff.s3 != state_ff.lvl);
        if (state_ff.s2 == state_ff.s3) begin
            nxt_state.lvl = state_ff.s3;
        end
        // timer only runs while verification is on
        if (!i_enable) begin
            nxt_state.cnt = '0;
            nxt_state.failed = 1'b0;
        end else if (beat) begin
            nxt_state.cnt = '0;
            if (state_ff.failed) begin
                nxt_state.failed = 1'b0;
                nxt_state.back = 1'b1;
            end
        end else if (state_ff.cnt == VERIFY_CNT_W'(VERIFY_TIMEOUT_CYC - 1)) begin
            // one fail event per outage, then wait for the loop to come back
            if (!state_ff.failed) begin
                nxt_state.fail = 1'b1;
                nxt_state.failed = 1'b1;
            end
        end else begin
            nxt_state.cnt = state_ff.cnt + 10'h001;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_fail = state_ff.fail;
    assign o_back = state_ff.back;
endmodule

// ===== ppc_clock_control_chk.sv
// port-level assertions for the pwm prescale and loop clock control block
// assumes it is bound onto ppc_clock_control and that the block has one clock domain
`timescale 1ns/10ps
module ppc_clock_control_chk
    import ppc_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // register bus
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic o_rvalid,
    input wire logic [31:0] o_rdata,
    // clock controls
    input wire logic i_system_divider_enable,
    input wire logic o_pwm_clk_en,
    input wire logic o_loop_power_down,
    input wire logic o_loop_output_enable,
    input wire logic o_source_select,
    input wire logic o_use_system_divider,
    input wire ppc_pkg::ppc_clk_cfg_t o_clk_cfg
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    // gap counts cycles since the last tick; stab waits out a select change so the old period is ignored
    logic [6:0] gap_ff;
    logic [6:0] stab_ff;
    logic [3:0] sel_q_ff;
    logic [3:0] sel_now;
    logic [6:0] div;
    assign sel_now = {o_clk_cfg.pwm_prescale_enable, o_clk_cfg.pwm_prescale_select};
    assign div = (o_clk_cfg.pwm_prescale_select > 3'h4) ? 7'h40 : (7'h02 << o_clk_cfg.pwm_prescale_select);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            gap_ff <= 7'h00;
            stab_ff <= 7'h00;
            sel_q_ff <= 4'h0;
        end else begin
            gap_ff <= o_pwm_clk_en ? 7'h00 : ((gap_ff == 7'h7f) ? gap_ff : gap_ff + 7'h01);
            sel_q_ff <= sel_now;
            stab_ff <= (sel_q_ff != sel_now) ? 7'h00 : ((stab_ff == 7'h7f) ? stab_ff : stab_ff + 7'h01);
        end
    end

    property p_pwm_period;
        o_clk_cfg.pwm_prescale_enable && stab_ff > 7'h46 && o_pwm_clk_en |-> gap_ff == div - 7'h01;
    endproperty
    a_pwm_period: assert property (p_pwm_period) else $error("pwm tick period wrong");
    property p_pwm_bound;
        o_clk_cfg.pwm_prescale_enable && stab_ff > 7'h46 |-> gap_ff < 7'h40;
    endproperty
    a_pwm_bound: assert property (p_pwm_bound) else $error("pwm tick missing");
    property p_pwm_bypass;
        !o_clk_cfg.pwm_prescale_enable [*3] |-> o_pwm_clk_en;
    endproperty
    a_pwm_bypass: assert property (p_pwm_bypass) else $error("pwm not on system clock");
    property p_power_down;
        o_loop_power_down == o_clk_cfg.loop_power_down
            && (!$changed(o_loop_power_down) || $rose(o_bvalid));
    endproperty
    a_power_down: assert property (p_power_down) else $error("power down differs from bit or moved without a write");
    property p_output_enable;
        o_loop_output_enable == o_clk_cfg.loop_output_enable
            && (!$changed(o_loop_output_enable) || $rose(o_bvalid));
    endproperty
    a_output_enable: assert property (p_output_enable) else $error("output enable differs from bit or moved without a write");
    property p_source;
        o_source_select == o_clk_cfg.source_select
            && (!$changed(o_source_select) || $rose(o_bvalid));
    endproperty
    a_source: assert property (p_source) else $error("source select differs from bit or moved without a write");
    property p_use_div;
        $stable(o_source_select) && $stable(i_system_divider_enable)
            |-> o_use_system_divider == (!o_source_select || i_system_divider_enable);
    endproperty
    a_use_div: assert property (p_use_div) else $error("system divider not forced");
    property p_reserved;
        o_rvalid |-> o_rdata[21] == 1'b0 && o_rdata[16:14] == 3'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");
    property p_b_answer;
        i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:3] o_bvalid;
    endproperty
    a_b_answer: assert property (p_b_answer) else $error("write response late");
    property p_r_answer;
        i_arvalid && o_arready |=> o_rvalid && !o_arready;
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("read data late");
endmodule

bind ppc_clock_control ppc_clock_control_chk u_chk (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rvalid(o_rvalid), .o_rdata(o_rdata),
    .i_system_divider_enable(i_system_divider_enable), .o_pwm_clk_en(o_pwm_clk_en),
    .o_loop_power_down(o_loop_power_down), .o_loop_output_enable(o_loop_output_enable),
    .o_source_select(o_source_select), .o_use_system_divider(o_use_system_divider), .o_clk_cfg(o_clk_cfg)
);

// ===== tb_top.sv
// self-checking bench for the clock control block, driven over its register bus
// assumes the package, the design files and the checker are compiled first
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    import ppc_pkg::*;
    logic i_clk = 1'b0, i_reset_n = 1'b0, i_loop_beat = 1'b0, i_system_divider_enable = 1'b0;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
    logic [11:0] i_awaddr = 12'h000, i_araddr = 12'h000;
    logic [31:0] i_wdata = 32'h0;
    logic [3:0] i_wstrb = 4'hf;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
    logic [1:0] o_bresp, o_rresp;
    logic [31:0] o_rdata;
    logic o_pwm_clk_en, o_loop_power_down, o_loop_output_enable, o_source_select, o_use_system_divider;
    ppc_clk_cfg_t o_clk_cfg;
    logic beat_run = 1'b0;
    int error_cnt = 0, n_tests = 0, cyc_cnt = 0, g;

    always #10 i_clk = ~i_clk;

    ppc_clock_control u_dut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_awvalid(i_awvalid), .o_awready(o_awready),
        .i_awaddr(i_awaddr), .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
        .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid),
        .o_arready(o_arready), .i_araddr(i_araddr), .o_rvalid(o_rvalid), .i_rready(i_rready),
        .o_rdata(o_rdata), .o_rresp(o_rresp), .i_system_divider_enable(i_system_divider_enable),
        .i_loop_beat(i_loop_beat), .o_pwm_clk_en(o_pwm_clk_en), .o_loop_power_down(o_loop_power_down),
        .o_loop_output_enable(o_loop_output_enable), .o_source_select(o_source_select),
        .o_use_system_divider(o_use_system_divider), .o_clk_cfg(o_clk_cfg), .o_irq(o_irq)
    );

    // heartbeat stands still while stopped, so the verify timer sees a dead loop
    always begin
        repeat (50) @(posedge i_clk);
        if (beat_run) begin
            i_loop_beat <= ~i_loop_beat;
        end
    end

    task automatic test_done();
        $display("TB: checks=%0d mismatches=%0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 12000) begin
            error_cnt++;
            test_done();
        end
    end

    // handshakes are judged at the falling edge so the rising edge that takes them is unambiguous
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        logic [1:0] r;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge i_clk);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(negedge i_clk);
            aw_ok = aw_ok || o_awready;
            w_ok = w_ok || o_wready;
            @(posedge i_clk);
            if (aw_ok) i_awvalid <= 1'b0;
            if (w_ok) i_wvalid <= 1'b0;
        end
        do @(negedge i_clk); while (!o_bvalid);
        r = o_bresp;
        @(posedge i_clk);
        i_bready <= 1'b0;
        `CHK(r, er)
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        @(posedge i_clk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do @(negedge i_clk); while (!o_arready);
        @(posedge i_clk);
        i_arvalid <= 1'b0;
        do @(negedge i_clk); while (!o_rvalid);
        d = o_rdata;
        r = o_rresp;
        @(posedge i_clk);
        i_rready <= 1'b0;
        `CHK(d, e)
        `CHK(r, er)
    endtask

    task automatic pwm_gap(output int n);
        n = 0;
        do @(negedge i_clk); while (!o_pwm_clk_en);
        do begin
            @(negedge i_clk);
            n++;
        end while (!o_pwm_clk_en && n < 200);
    endtask

    initial begin
        repeat (10) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd_chk(RUN_MODE_CLOCK_CONFIGURATION_OFFSET, 32'h000e3800, RESP_OKAY);
        rd_chk(IRQ_MASK_OFFSET, 32'h0, RESP_OKAY);
        @(negedge i_clk);
        `CHK({o_loop_power_down, o_loop_output_enable, o_source_select}, 3'h7)
        `CHK(o_clk_cfg, CLK_CFG_RESET)
        axi_wr(RUN_MODE_CLOCK_CONFIGURATION_OFFSET, 32'hffffffff, RESP_OKAY);
        rd_chk(RUN_MODE_CLOCK_CONFIGURATION_OFFSET, 32'h001e3c00, RESP_OKAY);
        axi_wr(12'h100, 32'hffffffff, RESP_SLVERR);
        rd_chk(12'h100, 32'h0, RESP_SLVERR);
        $display("TB: reset and map test done");
        for (int s = 0; s < 8; s++) begin
            axi_wr(RUN_MODE_CLOCK_CONFIGURATION_OFFSET, 32'h00103800 | (32'(s) << 17), RESP_OKAY);
            repeat (80) @(posedge i_clk);
            pwm_gap(g);
            `CHK(g, (s > 4) ? 64 : (2 << s))
        end
        axi_wr(RUN_MODE_CLOCK_CONFIGURATION_OFFSET, 32'h000e3800, RESP_OKAY);
        repeat (3) @(posedge i_clk);
        for (int k = 0; k < 8; k++) begin
            @(negedge i_clk);
            `CHK(o_pwm_clk_en, 1'b1)
        end
        $display("TB: pwm prescale test done");
        `CHK(o_use_system_divider, 1'b0)
        axi_wr(RUN_MODE_CLOCK_CONFIGURATION_OFFSET, 32'h000e0000, RESP_OKAY);
        repeat (2) @(negedge i_clk);
        `CHK({o_loop_power_down, o_loop_output_enable, o_source_select, o_use_system_divider}, 4'h1)
        axi_wr(RUN_MODE_CLOCK_CONFIGURATION_OFFSET, 32'h000e0800, RESP_OKAY);
        i_system_divider_enable <= 1'b1;
        repeat (3) @(negedge i_clk);
        `CHK({o_source_select, o_use_system_divider}, 2'h3)
        $display("TB: source select test done");
        axi_wr(IRQ_MASK_OFFSET, 32'h3, RESP_OKAY);
        beat_run <= 1'b1;
        axi_wr(RUN_MODE_CLOCK_CONFIGURATION_OFFSET, 32'h000e0400, RESP_OKAY);
        repeat (700) @(posedge i_clk);
        rd_chk(IRQ_STATUS_OFFSET, 32'h0, RESP_OKAY);
        beat_run <= 1'b0;
        repeat (600) @(posedge i_clk);
        rd_chk(IRQ_STATUS_OFFSET, 32'h1, RESP_OKAY);
        @(negedge i_clk);
        `CHK(o_irq, 1'b1)
        beat_run <= 1'b1;
        repeat (200) @(posedge i_clk);
        rd_chk(IRQ_STATUS_OFFSET, 32'h3, RESP_OKAY);
        axi_wr(IRQ_STATUS_OFFSET, 32'h3, RESP_OKAY);
        rd_chk(IRQ_STATUS_OFFSET, 32'h0, RESP_OKAY);
        @(negedge i_clk);
        `CHK(o_irq, 1'b0)
        axi_wr(IRQ_MASK_OFFSET, 32'h0, RESP_OKAY);
        beat_run <= 1'b0;
        repeat (600) @(posedge i_clk);
        rd_chk(IRQ_STATUS_OFFSET, 32'h1, RESP_OKAY);
        @(negedge i_clk);
        `CHK(o_irq, 1'b0)
        axi_wr(IRQ_MASK_OFFSET, 32'h1, RESP_OKAY);
        repeat (3) @(negedge i_clk);
        `CHK(o_irq, 1'b1)
        // with the timer off a dead loop must stay silent
        axi_wr(RUN_MODE_CLOCK_CONFIGURATION_OFFSET, 32'h000e0000, RESP_OKAY);
        axi_wr(IRQ_STATUS_OFFSET, 32'h3, RESP_OKAY);
        repeat (700) @(posedge i_clk);
        rd_chk(IRQ_STATUS_OFFSET, 32'h0, RESP_OKAY);
        $display("TB: loop verify test done");
        test_done();
    end
endmodule
